// ---- ris_ref_select.v ----
// Notes on behaviour
// - mode field: 00 manual, 01 auto, 10 manual (same as 00), 11 auto holdover.
// - manual modes route input named by choice field; field resets to 00.
// - in automatic modes the reference choice field is ignored.
// - auto-with-holdover uses 8-bit hold-off down-counter; zero triggers switch.
// - counter starts counting down when active input loses signal.
// - counter steps once per divided oscillator tick.
// - counter reloads from hold-off setting after each zero transition.
// - hold-off count setting resets to 0x80.
// - rate divider resets to 10 and only affects auto-with-holdover.
// - rate divider codes 00, 01, 10 divide by 2^15, 2^16, 2^17.
// - automatic modes pick the input from loss flags and priority.
// - selection mode resets to 00, manual choice.
`timescale 1ns/100ps
`include "ris_defs.vh"

module ris_ref_select
(
    // clock and reset
    input  wire             mclk_i,
    input  wire             rst_i,
    // register port
    input  wire [7:0]       reg_addr_i,
    input  wire [7:0]       reg_wdata_i,
    input  wire             reg_we_i,
    output reg  [7:0]       reg_rdata_o,
    // reference inputs and loss flags
    input  wire [3:0]       ref_in_i,
    input  wire [3:0]       los_i,
    // routed reference and status
    output reg              ref_out_o,
    output reg  [1:0]       active_sel_o,
    output reg              holdoff_busy_o,
    output reg              switch_o,
    output reg  [7:0]       holdoff_left_o
);

    reg  [3:0]              ref_meta_r;
    reg  [3:0]              ref_sync_r;
    reg  [1:0]              mode_r;
    reg  [1:0]              sel_r;
    reg  [7:0]              hcnt_r;
    reg  [1:0]              rate_r;
    reg  [1:0]              want_r;
    reg  [1:0]              want_nxt;
    reg                     state_r;
    reg                     state_nxt;
    reg  [7:0]              hold_r;
    reg  [7:0]              hold_nxt;
    reg                     switch_nxt;
    reg                     clear_nxt;
    reg                     clear_r;
    reg  [1:0]              cand;
    reg                     cand_ok;
    reg  [7:0]              rdata_nxt;
    wire                    tick;
    wire                    auto_mode;
    wire                    want_lost;
    wire                    apply_ok;
    integer                 i;

    localparam ST_IDLE = 1'b0;
    localparam ST_HOLD = 1'b1;

    // ************************************************************
    // reference synchronisers
    // ************************************************************
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ref_meta_r <= 4'h0;
            ref_sync_r <= 4'h0;
        end
        else
        begin
            ref_meta_r <= ref_in_i;
            ref_sync_r <= ref_meta_r;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_r <= `RIS_RST_MODE;
            sel_r  <= `RIS_RST_SEL;
            hcnt_r <= `RIS_RST_HCNT;
            rate_r <= `RIS_RST_RATE;
        end
        else if (reg_we_i)
        begin
            case (reg_addr_i)
                `RIS_ADDR_MODE:
                begin
                    mode_r <= reg_wdata_i[`RIS_MODE_LSB+1:`RIS_MODE_LSB];
                    sel_r  <= reg_wdata_i[`RIS_SEL_LSB+1:`RIS_SEL_LSB];
                end
                `RIS_ADDR_HCNT:
                    hcnt_r <= reg_wdata_i;
                `RIS_ADDR_HRATE:
                    rate_r <= reg_wdata_i[`RIS_RATE_LSB+1:`RIS_RATE_LSB];
                default:
                    mode_r <= mode_r;
            endcase
        end
    end

    // unused bits and unmapped addresses read as zero
    always @*
    begin
        case (reg_addr_i)
            `RIS_ADDR_MODE:  rdata_nxt = {4'h0, mode_r, sel_r};
            `RIS_ADDR_HCNT:  rdata_nxt = hcnt_r;
            `RIS_ADDR_HRATE: rdata_nxt = {rate_r, 6'h00};
            default:         rdata_nxt = 8'h00;
        endcase
    end

    // ************************************************************
    // automatic candidate: first healthy input, input 0 highest
    // ************************************************************
    always @*
    begin
        cand    = want_r;
        cand_ok = 1'b0;
        for (i = 3; i >= 0; i = i - 1)
        begin
            if (!los_i[i] && (i[1:0] != want_r))
            begin
                cand    = i[1:0];
                cand_ok = 1'b1;
            end
        end
    end

    assign auto_mode = mode_r[0];
    assign want_lost = los_i[want_r];

    // ************************************************************
    // hold-off tick generator
    // ************************************************************
    ris_tick_gen
    #(
        .PRE_W   (`RIS_PRE_W)
    )
    u_tick
    (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .rate_i  (rate_r),
        .clear_i (clear_r),
        .tick_o  (tick)
    );

    // ************************************************************
    // selection state machine
    // ************************************************************
    always @*
    begin
        want_nxt   = want_r;
        state_nxt  = state_r;
        hold_nxt   = hold_r;
        switch_nxt = 1'b0;
        clear_nxt  = 1'b0;
        case (mode_r)
            `RIS_MODE_MANUAL, `RIS_MODE_SHORT:
            begin
                want_nxt  = sel_r;
                state_nxt = ST_IDLE;
                hold_nxt  = hcnt_r;
                clear_nxt = 1'b1;
            end
            `RIS_MODE_AUTO:
            begin
                state_nxt = ST_IDLE;
                hold_nxt  = hcnt_r;
                clear_nxt = 1'b1;
                if (want_lost && cand_ok)
                begin
                    want_nxt   = cand;
                    switch_nxt = 1'b1;
                end
            end
            `RIS_MODE_AUTOHOLD:
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        hold_nxt  = hcnt_r;
                        clear_nxt = 1'b1;
                        if (want_lost)
                            state_nxt = ST_HOLD;
                    end
                    ST_HOLD:
                    begin
                        if (!want_lost)
                        begin
                            // keep the input, rearm from full count
                            state_nxt = ST_IDLE;
                            hold_nxt  = hcnt_r;
                        end
                        else if (tick || hold_r == 8'h00)
                        begin
                            if (hold_r <= 8'h01)
                            begin
                                hold_nxt  = hcnt_r;
                                state_nxt = ST_IDLE;
                                if (cand_ok)
                                begin
                                    want_nxt   = cand;
                                    switch_nxt = 1'b1;
                                end
                            end
                            else
                                hold_nxt = hold_r - 8'h01;
                        end
                    end
                    default:
                        state_nxt = ST_IDLE;
                endcase
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            want_r   <= `RIS_RST_SEL;
            state_r  <= ST_IDLE;
            hold_r   <= `RIS_RST_HCNT;
            clear_r  <= 1'b1;
            switch_o <= 1'b0;
        end
        else
        begin
            want_r   <= want_nxt;
            state_r  <= state_nxt;
            hold_r   <= hold_nxt;
            clear_r  <= clear_nxt;
            switch_o <= switch_nxt;
        end
    end

    // ************************************************************
    // glitch-free routing
    // ************************************************************
    // switch only while old output and new input are both low; a dead
    // old input cannot hold the change off, a stuck-high new one can
    assign apply_ok = (!ref_out_o || los_i[active_sel_o]) &&
                      !ref_sync_r[want_r];

    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            active_sel_o   <= `RIS_RST_SEL;
            ref_out_o      <= 1'b0;
            holdoff_busy_o <= 1'b0;
            holdoff_left_o <= `RIS_RST_HCNT;
            reg_rdata_o    <= 8'h00;
        end
        else
        begin
            if (apply_ok)
            begin
                active_sel_o <= want_r;
                ref_out_o    <= ref_sync_r[want_r];
            end
            else
                ref_out_o <= ref_sync_r[active_sel_o];
            holdoff_busy_o <= (state_r == ST_HOLD);
            holdoff_left_o <= hold_r;
            reg_rdata_o    <= rdata_nxt;
        end
    end

endmodule

// ---- ris_defs.vh ----
`ifndef RIS_DEFS_VH
`define RIS_DEFS_VH

// ************************************************************
// register addresses
// ************************************************************
`define RIS_ADDR_MODE      8'h15
`define RIS_ADDR_HCNT      8'h16
`define RIS_ADDR_HRATE     8'h17

// ************************************************************
// field positions
// ************************************************************
`define RIS_MODE_LSB       2
`define RIS_SEL_LSB        0
`define RIS_RATE_LSB       6

// ************************************************************
// selection modes
// ************************************************************
`define RIS_MODE_MANUAL    2'h0
`define RIS_MODE_AUTO      2'h1
`define RIS_MODE_SHORT     2'h2
`define RIS_MODE_AUTOHOLD  2'h3

// ************************************************************
// rate divider codes and prescaler size
// ************************************************************
`define RIS_RATE_DIV15     2'h0
`define RIS_RATE_DIV16     2'h1
`define RIS_RATE_DIV17     2'h2
`define RIS_PRE_W          17

// ************************************************************
// reset values
// ************************************************************
`define RIS_RST_MODE       2'h0
`define RIS_RST_SEL        2'h0
`define RIS_RST_HCNT       8'h80
`define RIS_RST_RATE       2'h2

`endif

// ---- ris_tick_gen.v ----
`timescale 1ns/100ps
`include "ris_defs.vh"

module ris_tick_gen
#(
    parameter PRE_W = `RIS_PRE_W
)
(
    // clock and reset
    input  wire             mclk_i,
    input  wire             rst_i,
    // control
    input  wire [1:0]       rate_i,
    input  wire             clear_i,
    // tick
    output reg              tick_o
);

    reg  [PRE_W-1:0]        cnt_r;
    reg                     tick_nxt;

    // ************************************************************
    // divide the oscillator clock by 2^15, 2^16 or 2^17
    // ************************************************************
    always @*
    begin
        case (rate_i)
            `RIS_RATE_DIV15: tick_nxt = &cnt_r[14:0];
            `RIS_RATE_DIV16: tick_nxt = &cnt_r[15:0];
            `RIS_RATE_DIV17: tick_nxt = &cnt_r[16:0];
            // spare code: slowest rate, safest hold-off
            default:         tick_nxt = &cnt_r[16:0];
        endcase
    end

    // clear restarts the period so the hold-off is count times tick
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r  <= {PRE_W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (clear_i)
        begin
            cnt_r  <= {PRE_W{1'b0}};
            tick_o <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_r + {{(PRE_W-1){1'b0}}, 1'b1};
            tick_o <= tick_nxt && (cnt_r != {PRE_W{1'b0}} || PRE_W == 0);
        end
    end

endmodule

// ---- ris_ref_select_monitor.sv ----
`timescale 1ns/100ps
module ris_ref_select_monitor
(
    // clock and reset
    input wire       mclk_i,
    input wire       rst_i,
    // register port
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       reg_we_i,
    input wire [7:0] reg_rdata_o,
    // references and status
    input wire [3:0] ref_in_i,
    input wire [3:0] los_i,
    input wire       ref_out_o,
    input wire [1:0] active_sel_o,
    input wire       holdoff_busy_o,
    input wire       switch_o,
    input wire [7:0] holdoff_left_o
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_cnt_write;
        reg_we_i && reg_addr_i == 8'h16 ##1 !reg_we_i && reg_addr_i == 8'h16;
    endsequence

    sequence s_route_moves;
        ##[0:8] $changed(active_sel_o);
    endsequence

    AST_RST_STATE: assert property ($fell(rst_i) |->
        reg_rdata_o == 8'h00 && active_sel_o == 2'h0 && !switch_o)
        else $error("state after reset wrong");
    AST_CNT_READBACK: assert property (s_cnt_write |=>
        reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("hold-off count readback wrong");
    AST_MODE_PAD: assert property (reg_addr_i == 8'h15 |=>
        reg_rdata_o[7:4] == 4'h0)
        else $error("mode register upper bits set");
    AST_RATE_PAD: assert property (reg_addr_i == 8'h17 |=>
        reg_rdata_o[5:0] == 6'h00)
        else $error("rate register low bits set");
    AST_SWITCH_PULSE: assert property (switch_o |=> !switch_o)
        else $error("switch pulse longer than one cycle");
    AST_STEP_ONE: assert property (holdoff_busy_o &&
        holdoff_left_o < $past(holdoff_left_o)
        |-> holdoff_left_o == $past(holdoff_left_o) - 8'h01)
        else $error("hold-off counter stepped by more than one");
    AST_ROUTE_LOW: assert property ($changed(active_sel_o) &&
        $past(los_i) == 4'h0 |-> !$past(ref_out_o))
        else $error("route changed while output high");
    AST_ROUTE_MOVES: assert property (switch_o |-> s_route_moves)
        else $error("switch without route change");
    AST_LOS_CLEAR: assert property (holdoff_busy_o && los_i == 4'h0
        |-> ##[1:3] !holdoff_busy_o)
        else $error("hold-off kept running after loss cleared");
    AST_REF_FOLLOW: assert property (
        (($past(ref_in_i, 3) >> active_sel_o) & 4'h1) == {3'h0, ref_out_o})
        else $error("routed reference does not follow selected input");
endmodule

bind ris_ref_select ris_ref_select_monitor u_mon
(
    .mclk_i        (mclk_i),
    .rst_i         (rst_i),
    .reg_addr_i    (reg_addr_i),
    .reg_wdata_i   (reg_wdata_i),
    .reg_we_i      (reg_we_i),
    .reg_rdata_o   (reg_rdata_o),
    .ref_in_i      (ref_in_i),
    .los_i         (los_i),
    .ref_out_o     (ref_out_o),
    .active_sel_o  (active_sel_o),
    .holdoff_busy_o(holdoff_busy_o),
    .switch_o      (switch_o),
    .holdoff_left_o(holdoff_left_o)
);

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "ris_defs.vh"
module testbench;
    reg        mclk_i;
    reg        rst_i;
    reg  [7:0] reg_addr_i;
    reg  [7:0] reg_wdata_i;
    reg        reg_we_i;
    wire [3:0] ref_in_i;
    reg  [1:0] ref_div;
    reg  [3:0] los_i;
    wire [7:0] reg_rdata_o;
    wire       ref_out_o;
    wire [1:0] active_sel_o;
    wire       holdoff_busy_o;
    wire       switch_o;
    wire [7:0] holdoff_left_o;
    integer    num_errors;
    integer    checks_done;
    integer    cyc;
    integer    i;
    reg  [2:0] k;

    ris_ref_select DUT
    (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_rdata_o(reg_rdata_o), .ref_in_i(ref_in_i), .los_i(los_i),
        .ref_out_o(ref_out_o), .active_sel_o(active_sel_o),
        .holdoff_busy_o(holdoff_busy_o), .switch_o(switch_o),
        .holdoff_left_o(holdoff_left_o)
    );

    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // refs toggle every second cycle: a one-cycle low phase could never
    // meet the old-output-low and new-input-low switch condition
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            ref_div <= 2'h0;
        else
            ref_div <= ref_div + 2'h1;
    end
    assign ref_in_i = {4{ref_div[1]}};

    // ****************
    // tasks
    // ****************
    task end_sim;
    begin
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // hold-off run is about 66k cycles at the fastest rate
    always @(posedge mclk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 90000)
        begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end

    task chk(input [7:0] got, input [7:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task tick(input integer n);
    begin
        repeat (n) @(posedge mclk_i);
        #1;
    end
    endtask

    task wr(input [7:0] a, input [7:0] d);
    begin
        tick(1);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_we_i = 1'b1;
        tick(1);
        reg_we_i = 1'b0;
    end
    endtask

    task rd(input [7:0] a, input [7:0] exp);
    begin
        tick(1);
        reg_addr_i = a;
        tick(1);
        chk(reg_rdata_o, exp);
    end
    endtask

    task wait_sw(input integer n);
    begin
        i = 0;
        while (switch_o !== 1'b1 && i < n)
        begin
            tick(1);
            i = i + 1;
        end
        chk({7'h00, switch_o}, 8'h01);
    end
    endtask

    // ****************
    // sequence
    // ****************
    initial
    begin
        {reg_addr_i, reg_wdata_i, reg_we_i, los_i} = 21'h0;
        rst_i = 1'b1;
        num_errors = 0;
        checks_done = 0;
        cyc = 0;
        tick(3);
        rst_i = 1'b0;
        rd(`RIS_ADDR_MODE, 8'h00);
        rd(`RIS_ADDR_HCNT, `RIS_RST_HCNT);
        rd(`RIS_ADDR_HRATE, 8'h80);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        $display("test reset values done");
        for (k = 3'h0; ; k = k + 3'h1)
        begin
            wr(`RIS_ADDR_MODE, {4'h0, k[2], 1'b0, k[1:0]});
            tick(8);
            chk({6'h00, active_sel_o}, {6'h00, k[1:0]});
            if (k == 3'h7)
                break;
        end
        $display("test manual routing done");
        wr(`RIS_ADDR_MODE, 8'h00);
        tick(8);
        wr(`RIS_ADDR_MODE, 8'h07);
        tick(8);
        chk({6'h00, active_sel_o}, 8'h00);
        los_i = 4'h1;
        wait_sw(10);
        tick(8);
        chk({6'h00, active_sel_o}, 8'h01);
        los_i = 4'h3;
        wait_sw(10);
        tick(8);
        chk({6'h00, active_sel_o}, 8'h02);
        los_i = 4'h0;
        $display("test automatic done");
        wr(`RIS_ADDR_HRATE, 8'h00);
        wr(`RIS_ADDR_HCNT, 8'h02);
        rd(`RIS_ADDR_HCNT, 8'h02);
        wr(`RIS_ADDR_MODE, 8'h0C);
        los_i = 4'h4;
        tick(4);
        chk({7'h00, holdoff_busy_o}, 8'h01);
        tick(100);
        los_i = 4'h0;
        tick(4);
        chk({7'h00, holdoff_busy_o}, 8'h00);
        chk({6'h00, active_sel_o}, 8'h02);
        chk(holdoff_left_o, 8'h02);
        los_i = 4'h4;
        tick(32700);
        chk(holdoff_left_o, 8'h02);
        tick(100);
        chk(holdoff_left_o, 8'h01);
        tick(32600);
        chk({7'h00, switch_o}, 8'h00);
        wait_sw(400);
        tick(8);
        chk({6'h00, active_sel_o}, 8'h00);
        chk(holdoff_left_o, 8'h02);
        $display("test hold-off done");
        end_sim;
    end
endmodule
